/* File: src/rtc_event_status.sv */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_defs.svh"

// Function
// - Day-of-month alarm, enable at bit 31
// - Month alarm, enable at bit 23
// - Disabled alarm field ignored in matching
// - Status bit 0 shows write window open
// - Status bit 1 set on alarm match
// - Status bit 2 sticky per second tick
// - Status bit 3 sticky on time event
// - Time event chosen by mode field
// - Status bit 4 sticky on date event
// - Date event chosen by mode field
// - Write one to 0x1C clears flag
// - Write one to 0x20 enables source
// - Write one to 0x24 disables source
// - Mask at 0x28 shows enables, resets zero
// - Validity bits 0,1 for time, date
// - Validity bits 2,3 for alarm registers
// - Time select codes minute hour midnight noon
// - Date select codes week month year reserved
// - Freeze request stops counting while set
// - BCD units low nibble, tens above
module rtc_event_status
  import rtc_event_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Counter side, same clock domain
  input  wire logic        secondTick,
  input  wire logic        minuteChange,
  input  wire logic        hourChange,
  input  wire logic        midnight,
  input  wire logic        noon,
  input  wire logic        mondayMidnight,
  input  wire logic        monthStart,
  input  wire logic        yearStart,
  input  wire logic [6:0]  secondCount,
  input  wire logic [6:0]  minuteCount,
  input  wire logic [7:0]  hourCount,
  input  wire logic [5:0]  dayCount,
  input  wire logic [4:0]  monthCount,
  input  wire logic [3:0]  badEntry,
  // Counter control and interrupt
  output logic             timeFreeze,
  output logic             dateFreeze,
  output logic             irq
);

  // ****************************************
  // Register state
  // ****************************************
  logic [31:0]                 mode;
  logic [31:0]                 timeAlarm;
  logic [31:0]                 dateAlarm;
  logic [`FLAG_COUNT-1:0]      flags;
  logic [`FLAG_COUNT-1:0]      irqMask;
  logic [`VALID_COUNT-1:0]     validity;
  window_state_e               winState;
  logic                        alarmHitQ;

  logic                        wrEn;
  logic                        access;
  logic                        mapped;
  logic [`FLAG_COUNT-1:0]      events;
  logic [`FLAG_COUNT-1:0]      clearBits;
  logic                        alarmHit;
  logic                        anyEnabled;
  logic                        clockEvent;
  logic                        dateEvent;
  logic                        freezeAny;
  clock_event_select_e         clockSel;
  date_event_select_e          dateSel;
  logic                        wrMode;
  logic                        wrTimeAlarm;
  logic                        wrDateAlarm;
  logic                        wrClear;
  logic                        wrIrqSet;
  logic                        wrIrqClear;
  logic                        secMatch;
  logic                        minMatch;
  logic                        hourMatch;
  logic                        dayMatch;
  logic                        monthMatch;
  logic [`FLAG_COUNT-1:0]      closeBits;
  logic [31:0]                 next_prdata;

  function automatic logic field_ok(input logic en, input logic [7:0] alarm, input logic [7:0] count);
    field_ok = !en || (alarm == count);
  endfunction : field_ok

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
    is_addr = (a == ofs);
  endfunction : is_addr

  // ****************************************
  // APB decode
  // ****************************************
  assign access = psel && penable;
  assign wrEn   = access && pwrite && !pready;
  assign mapped = is_addr(paddr, `OFS_MODE) || is_addr(paddr, `OFS_TIME_ALARM)
               || is_addr(paddr, `OFS_DATE_ALARM) || is_addr(paddr, `OFS_EVENT_STATUS)
               || is_addr(paddr, `OFS_EVENT_CLEAR) || is_addr(paddr, `OFS_IRQ_SET)
               || is_addr(paddr, `OFS_IRQ_CLEAR) || is_addr(paddr, `OFS_IRQ_STATE)
               || is_addr(paddr, `OFS_ENTRY_VALIDITY);

  // ****************************************
  // Register write strobes
  // ****************************************
  // Taken on the first access-phase edge, one cycle before pready
  assign wrMode      = wrEn && is_addr(paddr, `OFS_MODE);
  assign wrTimeAlarm = wrEn && is_addr(paddr, `OFS_TIME_ALARM);
  assign wrDateAlarm = wrEn && is_addr(paddr, `OFS_DATE_ALARM);
  assign wrClear     = wrEn && is_addr(paddr, `OFS_EVENT_CLEAR);
  assign wrIrqSet    = wrEn && is_addr(paddr, `OFS_IRQ_SET);
  assign wrIrqClear  = wrEn && is_addr(paddr, `OFS_IRQ_CLEAR);

  // One wait state: pready rises in the second access cycle, a pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  // Error rides on pready for an offset that maps to nothing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && !pready && !mapped;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Registered below so the word stays after pready falls
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (1'b1)
      is_addr(paddr, `OFS_MODE):           next_prdata = mode;
      is_addr(paddr, `OFS_TIME_ALARM):     next_prdata = timeAlarm;
      is_addr(paddr, `OFS_DATE_ALARM):     next_prdata = dateAlarm;
      is_addr(paddr, `OFS_EVENT_STATUS):   next_prdata = {27'h000_0000, flags};
      is_addr(paddr, `OFS_IRQ_STATE):      next_prdata = {27'h000_0000, irqMask};
      is_addr(paddr, `OFS_ENTRY_VALIDITY): next_prdata = {28'h000_0000, validity};
      default:                             next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode      <= `RST_MODE;
      timeAlarm <= `RST_TIME_ALARM;
      dateAlarm <= `RST_DATE_ALARM;
    end else begin
      if (wrMode) begin
        mode <= pwdata & `MASK_MODE;
      end
      if (wrTimeAlarm) begin
        timeAlarm <= pwdata & `MASK_TIME_ALARM;
      end
      if (wrDateAlarm) begin
        dateAlarm <= pwdata & `MASK_DATE_ALARM;
      end
    end
  end

  // freeze outputs
  // Registered so the counters see a clean level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timeFreeze <= 1'b0;
      dateFreeze <= 1'b0;
    end else begin
      timeFreeze <= mode[`POS_TIME_FREEZE];
      dateFreeze <= mode[`POS_DATE_FREEZE];
    end
  end

  // ****************************************
  // Alarm compare
  // ****************************************
  // BCD fields compared nibble-wise as stored
  assign anyEnabled = timeAlarm[`POS_SEC_MATCH_EN] || timeAlarm[`POS_MIN_MATCH_EN]
                   || timeAlarm[`POS_HOUR_MATCH_EN] || dateAlarm[`POS_DAY_MATCH_EN]
                   || dateAlarm[`POS_MONTH_MATCH_EN];
  // Seconds and minutes, seven BCD bits each
  assign secMatch   = field_ok(timeAlarm[`POS_SEC_MATCH_EN], {1'b0, timeAlarm[6:0]}, {1'b0, secondCount});
  assign minMatch   = field_ok(timeAlarm[`POS_MIN_MATCH_EN], {1'b0, timeAlarm[14:8]}, {1'b0, minuteCount});
  // Hour compares with its AM/PM bit; counter bit 7 is unused
  assign hourMatch  = field_ok(timeAlarm[`POS_HOUR_MATCH_EN], {1'b0, timeAlarm[22:16]}, {1'b0, hourCount[6:0]});
  assign dayMatch   = field_ok(dateAlarm[`POS_DAY_MATCH_EN], {2'b00, dateAlarm[29:24]}, {2'b00, dayCount});
  assign monthMatch = field_ok(dateAlarm[`POS_MONTH_MATCH_EN], {3'b000, dateAlarm[20:16]}, {3'b000, monthCount});
  assign alarmHit = anyEnabled && secMatch && minMatch && hourMatch && dayMatch && monthMatch;

  // Edge on the match so a held match flags once, not every cycle after a clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarmHitQ <= 1'b0;
    end else begin
      alarmHitQ <= alarmHit;
    end
  end

  // ****************************************
  // Event selection
  // ****************************************
  assign clockSel  = clock_event_select_e'(mode[`POS_CLOCK_EV_LSB +: 2]);
  assign dateSel   = date_event_select_e'(mode[`POS_DATE_EV_LSB +: 2]);
  assign freezeAny = mode[`POS_TIME_FREEZE] || mode[`POS_DATE_FREEZE];

  always_comb begin
    unique case (clockSel)
      CLK_EV_MINUTE:   clockEvent = minuteChange;
      CLK_EV_HOUR:     clockEvent = hourChange;
      CLK_EV_MIDNIGHT: clockEvent = midnight;
      CLK_EV_NOON:     clockEvent = noon;
    endcase
  end

  always_comb begin
    unique case (dateSel)
      DATE_EV_WEEK:     dateEvent = mondayMidnight;
      DATE_EV_MONTH:    dateEvent = monthStart;
      DATE_EV_YEAR:     dateEvent = yearStart;
      DATE_EV_RESERVED: dateEvent = 1'b0;
    endcase
  end

  // ****************************************
  // Write window handshake
  // ****************************************
  // acknowledge waits for a second boundary
  // Dropping both requests returns to counting at once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      winState <= WIN_COUNTING;
    end else begin
      unique case (winState)
        WIN_COUNTING:    if (freezeAny) winState <= WIN_WAIT_SECOND;
        WIN_WAIT_SECOND: if (!freezeAny) winState <= WIN_COUNTING;
                         else if (secondTick) winState <= WIN_OPEN;
        WIN_OPEN:        if (!freezeAny) winState <= WIN_COUNTING;
        default:         winState <= WIN_COUNTING;
      endcase
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  always_comb begin
    events = '0;
    events[`FLAG_ACK]   = (winState == WIN_WAIT_SECOND) && freezeAny && secondTick;
    events[`FLAG_ALARM] = alarmHit && !alarmHitQ;
    events[`FLAG_SEC]   = secondTick;
    events[`FLAG_TIME]  = clockEvent;
    events[`FLAG_DATE]  = dateEvent;
  end

  assign clearBits = wrClear ? pwdata[`FLAG_COUNT-1:0] : '0;

  // acknowledge drops once no freeze is requested
  assign closeBits = {{(`FLAG_COUNT-1){1'b0}}, !freezeAny};

  // sticky event flags
  // New events win over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      for (int i = 0; i < `FLAG_COUNT; i++) begin
        if (events[i]) begin
          flags[i] <= 1'b1;
        end else if (clearBits[i] || closeBits[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Interrupt mask
  // ****************************************
  // set on enable write
  // mask resets to zero
  // Set and clear sit at different offsets, so they never collide
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqMask <= '0;
    end else if (wrIrqSet) begin
      irqMask <= irqMask | pwdata[`FLAG_COUNT-1:0];
    end else if (wrIrqClear) begin
      irqMask <= irqMask & ~pwdata[`FLAG_COUNT-1:0];
    end
  end

  // masked flags drive the interrupt
  // Registered output, one cycle behind a flag or mask change
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irqMask);
    end
  end

  // ****************************************
  // Entry validity
  // ****************************************
  // time and date validity from counter checker
  // alarm validity; a write to the register clears its bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      validity <= '0;
    end else begin
      validity[0] <= badEntry[0];
      validity[1] <= badEntry[1];
      validity[2] <= badEntry[2] || (validity[2] && !wrTimeAlarm);
      validity[3] <= badEntry[3] || (validity[3] && !wrDateAlarm);
    end
  end

endmodule : rtc_event_status
`default_nettype wire

/* File: common/rtc_event_defs.svh */
`ifndef RTC_EVENT_DEFS_SVH
`define RTC_EVENT_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODE             12'h000
`define OFS_TIME_ALARM       12'h010
`define OFS_DATE_ALARM       12'h014
`define OFS_EVENT_STATUS     12'h018
`define OFS_EVENT_CLEAR      12'h01c
`define OFS_IRQ_SET          12'h020
`define OFS_IRQ_CLEAR        12'h024
`define OFS_IRQ_STATE        12'h028
`define OFS_ENTRY_VALIDITY   12'h02c

// ****************************************
// Field positions
// ****************************************
`define POS_DAY_MATCH_EN     31
`define POS_MONTH_MATCH_EN   23
`define POS_DAY_LSB          24
`define POS_MONTH_LSB        16
`define POS_HOUR_MATCH_EN    23
`define POS_MIN_MATCH_EN     15
`define POS_SEC_MATCH_EN     7
`define POS_TIME_FREEZE      0
`define POS_DATE_FREEZE      1
`define POS_CLOCK_EV_LSB     8
`define POS_DATE_EV_LSB      16

`define FLAG_ACK             0
`define FLAG_ALARM           1
`define FLAG_SEC             2
`define FLAG_TIME            3
`define FLAG_DATE            4

// ****************************************
// Reset values and masks
// ****************************************
`define RST_DATE_ALARM       32'h0000_0000
`define RST_TIME_ALARM       32'h0000_0000
`define RST_MODE             32'h0000_0000
`define MASK_DATE_ALARM      32'hbf9f_0000
`define MASK_TIME_ALARM      32'h00ff_ffff
`define MASK_MODE            32'h0003_0303
`define FLAG_COUNT           5
`define VALID_COUNT          4

`endif

/* File: common/rtc_event_pkg.sv */
package rtc_event_pkg;
  typedef enum logic [1:0] {
    CLK_EV_MINUTE,
    CLK_EV_HOUR,
    CLK_EV_MIDNIGHT,
    CLK_EV_NOON
  } clock_event_select_e;

  typedef enum logic [1:0] {
    DATE_EV_WEEK,
    DATE_EV_MONTH,
    DATE_EV_YEAR,
    DATE_EV_RESERVED
  } date_event_select_e;

  typedef enum logic [1:0] {
    WIN_COUNTING,
    WIN_WAIT_SECOND,
    WIN_OPEN
  } window_state_e;
endpackage : rtc_event_pkg

/* File: bench/rtc_event_status_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_defs.svh"
module rtc_event_status_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Control and interrupt
  input wire logic        timeFreeze,
  input wire logic        dateFreeze,
  input wire logic        irq
);
  logic maskSeen;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_start;
    psel && $rose(penable);
  endsequence
  sequence s_mode_wr;
    s_start ##0 (pwrite && paddr == `OFS_MODE);
  endsequence
  // Partial disables keep it set, so this only bounds irq from above
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      maskSeen <= 1'b0;
    end else if (psel && penable && !pready && pwrite) begin
      if (paddr == `OFS_IRQ_SET && pwdata[4:0] != 5'h00) maskSeen <= 1'b1;
      else if (paddr == `OFS_IRQ_CLEAR && pwdata[4:0] == 5'h1f) maskSeen <= 1'b0;
    end
  end
  AST_ONE_WAIT: assert property (s_start |=> pready)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED_ERR: assert property (s_start ##0 paddr > 12'h02c |=> pslverr)
    else $error("unmapped access not refused");
  AST_PRDATA_ON_READ: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  AST_FREEZE_VALUE: assert property (s_mode_wr |-> ##2 {dateFreeze, timeFreeze} == $past(pwdata[1:0], 2))
    else $error("freeze outputs do not follow mode write");
  AST_FREEZE_ON_WRITE: assert property ($changed({dateFreeze, timeFreeze}) |-> $past(psel && pwrite && paddr == `OFS_MODE))
    else $error("freeze changed without mode write");
  AST_IRQ_ALL_OFF: assert property (s_start ##0 (pwrite && paddr == `OFS_IRQ_CLEAR && pwdata[4:0] == 5'h1f) |-> ##2 !irq)
    else $error("irq still high after disabling all");
  AST_IRQ_NEEDS_MASK: assert property (irq |-> $past(maskSeen))
    else $error("irq with no source enabled");
endmodule : rtc_event_status_chk
bind rtc_event_status rtc_event_status_chk i_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .timeFreeze(timeFreeze), .dateFreeze(dateFreeze), .irq(irq));
`default_nettype wire

/* File: bench/tb_rtc_event_status.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_defs.svh"
module tb_rtc_event_status
  import rtc_event_pkg::*;
;
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  // Event pulses: sec, min, hour, midnight, noon, monday, month, year
  logic [7:0]  evs = 0;
  logic [5:0]  dayCount = 0;
  logic [4:0]  monthCount = 0;
  logic [3:0]  badEntry = 0;
  wire logic   pready, pslverr, timeFreeze, dateFreeze, irq;
  wire logic [31:0] prdata;
  int          fails = 0, testsRun = 0;
  always #2.5 mclk = ~mclk;
  rtc_event_status i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .secondTick(evs[0]), .minuteChange(evs[1]), .hourChange(evs[2]), .midnight(evs[3]), .noon(evs[4]),
    .mondayMidnight(evs[5]), .monthStart(evs[6]), .yearStart(evs[7]), .secondCount(7'h00),
    .minuteCount(7'h00), .hourCount(8'h00), .dayCount(dayCount), .monthCount(monthCount),
    .badEntry(badEntry), .timeFreeze(timeFreeze), .dateFreeze(dateFreeze), .irq(irq));
  // ****************************************
  // Access and compare
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Idle cycle after each transfer so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      $display("[ERR] %0t no ready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask : rc
  task automatic pulse(input logic [7:0] m);
    evs <= m;
    @(posedge mclk);
    evs <= 8'h00;
    repeat (3) @(posedge mclk);
  endtask : pulse
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #20000;
    fails++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rc(`OFS_DATE_ALARM, 32'h0000_0000);
    rc(`OFS_EVENT_STATUS, 32'h0000_0000);
    rc(`OFS_ENTRY_VALIDITY, 32'h0000_0000);
    rc(`OFS_IRQ_SET, 32'h0000_0000);
    rc(12'h030, 32'h0000_0000);
    chk({31'b0, e}, 32'h0000_0001);
    wr(`OFS_IRQ_STATE, 32'hffff_ffff);
    rc(`OFS_IRQ_STATE, 32'h0000_0000);
    wr(`OFS_DATE_ALARM, 32'hffff_ffff);
    rc(`OFS_DATE_ALARM, 32'hbf9f_0000);
    wr(`OFS_DATE_ALARM, 32'h0000_0000);
    wr(`OFS_IRQ_SET, 32'h0000_001f);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0005);
    wr(`OFS_IRQ_SET, 32'h0000_0000);
    rc(`OFS_IRQ_STATE, 32'h0000_001a);
    pulse(8'h01);
    pulse(8'h01);
    chk({31'b0, irq}, 32'h0000_0000);
    wr(`OFS_IRQ_SET, 32'h0000_0004);
    chk({31'b0, irq}, 32'h0000_0001);
    wr(`OFS_EVENT_CLEAR, 32'h0000_001b);
    rc(`OFS_EVENT_STATUS, 32'h0000_0004);
    wr(`OFS_EVENT_CLEAR, 32'h0000_0004);
    rc(`OFS_EVENT_STATUS, 32'h0000_0000);
    chk({31'b0, irq}, 32'h0000_0000);
    wr(`OFS_IRQ_CLEAR, 32'h0000_001f);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_MODE, 32'(k) << 8);
      pulse(8'h02 << ((k + 1) % 4));
      rc(`OFS_EVENT_STATUS, 32'h0000_0000);
      pulse(8'h02 << k);
      rc(`OFS_EVENT_STATUS, 32'h0000_0008);
      wr(`OFS_EVENT_CLEAR, 32'h0000_0008);
    end
    // Code 3 is reserved and must raise nothing
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_MODE, 32'(k) << 16);
      pulse(8'h20 << ((k + 1) % 3));
      rc(`OFS_EVENT_STATUS, 32'h0000_0000);
      pulse(8'h20 << (k % 3));
      rc(`OFS_EVENT_STATUS, k < 3 ? 32'h0000_0010 : 32'h0000_0000);
      wr(`OFS_EVENT_CLEAR, 32'h0000_0010);
    end
    wr(`OFS_MODE, 32'h0000_0003);
    chk({30'b0, dateFreeze, timeFreeze}, 32'h0000_0003);
    rc(`OFS_EVENT_STATUS, 32'h0000_0000);
    pulse(8'h01);
    rc(`OFS_EVENT_STATUS, 32'h0000_0005);
    wr(`OFS_MODE, 32'h0000_0000);
    chk({30'b0, dateFreeze, timeFreeze}, 32'h0000_0000);
    rc(`OFS_EVENT_STATUS, 32'h0000_0004);
    wr(`OFS_EVENT_CLEAR, 32'h0000_001f);
    dayCount <= 6'h15;
    monthCount <= 5'h03;
    wr(`OFS_DATE_ALARM, 32'h9512_0000);
    rc(`OFS_EVENT_STATUS, 32'h0000_0002);
    wr(`OFS_EVENT_CLEAR, 32'h0000_0002);
    wr(`OFS_DATE_ALARM, 32'h9592_0000);
    rc(`OFS_EVENT_STATUS, 32'h0000_0000);
    monthCount <= 5'h12;
    repeat (3) @(posedge mclk);
    rc(`OFS_EVENT_STATUS, 32'h0000_0002);
    badEntry <= 4'hf;
    repeat (2) @(posedge mclk);
    rc(`OFS_ENTRY_VALIDITY, 32'h0000_000f);
    badEntry <= 4'h0;
    repeat (2) @(posedge mclk);
    rc(`OFS_ENTRY_VALIDITY, 32'h0000_000c);
    wr(`OFS_TIME_ALARM, 32'h0000_0000);
    wr(`OFS_DATE_ALARM, 32'h0000_0000);
    rc(`OFS_ENTRY_VALIDITY, 32'h0000_0000);
    wr(`OFS_EVENT_CLEAR, 32'h0000_0002);
    wr(`OFS_TIME_ALARM, 32'h0080_8000);
    rc(`OFS_EVENT_STATUS, 32'h0000_0002);
    close_out();
  end
endmodule : tb_rtc_event_status
`default_nettype wire
